// file: pkg/sarl_params.svh
// Constants for the setpoint alarm and relay block
`ifndef SARL_PARAMS_SVH
`define SARL_PARAMS_SVH

// =====================================================================
// Sizes
`define SARL_NCH          8
`define SARL_NRLY         4
`define SARL_VAL_W        16
`define SARL_ADDR_W       8

// =====================================================================
// Register offsets (word index within an alarm, then bytes)
`define SARL_OFS_LOW      2'h0
`define SARL_OFS_HIGH     2'h1
`define SARL_OFS_DLY      2'h2
`define SARL_OFS_MISC     2'h3
`define SARL_OFS_CTRL     8'h80
`define SARL_OFS_STATUS   8'h84

// =====================================================================
// Field positions
`define SARL_EN_BIT       31
`define SARL_REL_LSB      16
`define SARL_TRAIL_LSB    16
`define SARL_ALLOC_LSB    20
`define SARL_PI_BIT       8
`define SARL_ACK_BIT      9
`define SARL_ST_ACT_LSB   8
`define SARL_ST_RLY_LSB   16

// =====================================================================
// Reset values and answers
`define SARL_DBAND_RST    16'h000a
`define SARL_RESP_OKAY    2'h0
`define SARL_RESP_SLVERR  2'h2

// =====================================================================
// Timing: 100 ms delay tick at a 4 ns clock
`define SARL_TICK_NS      100000000
`define SARL_CLK_NS       4
`define SARL_TICK_CYCLES  (`SARL_TICK_NS / `SARL_CLK_NS)

`endif

// file: pkg/sarl_pkg.sv
// Types shared by the setpoint alarm and relay block
`default_nettype none
`include "sarl_params.svh"

package sarl_pkg;

  // ===================================================================
  // Values and configuration
  typedef logic signed [17:0] sarl_wide_t;

  typedef struct packed {
    logic        lo_en;
    logic        hi_en;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] dband;
    logic [15:0] act;
    logic [15:0] rel;
    logic [2:0]  trail;
    logic [3:0]  alloc;
  } sarl_cfg_s;

  typedef enum logic [2:0] {
    SARL_ANN_OFF    = 3'h1,
    SARL_ANN_FLASH  = 3'h2,
    SARL_ANN_STEADY = 3'h4
  } sarl_ann_e;

  // ===================================================================
  // Module state
  typedef struct packed {
    sarl_cfg_s [`SARL_NCH-1:0]  cfg;
    logic [`SARL_NRLY-1:0]      and_mode;
    logic                       pi_mode;
    logic                       aw_have;
    logic [`SARL_ADDR_W-1:0]    awaddr;
    logic                       w_have;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [2:0]                 ack_sync;
    logic                       ack_lvl;
    logic                       blink;
    sarl_ann_e [`SARL_NRLY-1:0] ann;
    logic [`SARL_NRLY-1:0]      relay;
    logic [`SARL_NRLY-1:0]      ann_out;
  } sarl_top_s;

  typedef struct packed {
    logic        qual;
    logic        active;
    logic [15:0] cnt;
  } sarl_chan_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } sarl_tick_s;

  // Sign-extend a 16-bit display quantity
  function automatic sarl_wide_t sarl_ext(input logic [15:0] x);
    return sarl_wide_t'(signed'(x));
  endfunction : sarl_ext

endpackage : sarl_pkg
`default_nettype wire

// file: rtl/sarl_tick.sv
// Tenth-of-a-second timing tick for the alarm delays
`timescale 1ns/100ps
`default_nettype none
`include "sarl_params.svh"

module sarl_tick #(
  parameter int unsigned CYCLES = `SARL_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick
  output logic      tick
);

  sarl_pkg::sarl_tick_s s, n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt >= CYCLES - 1) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 32'h1;
    end
    if (!aresetn) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s <= n;
  end

  assign tick = s.tick;

endmodule : sarl_tick
`default_nettype wire

// file: rtl/sarl_chan.sv
// One alarm channel: compare with deadband, then trip and reset delays
`timescale 1ns/100ps
`default_nettype none
`include "sarl_params.svh"

module sarl_chan (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Timing and measured value
  input  wire logic                          tick,
  input  wire logic signed [`SARL_VAL_W-1:0] value,
  // Configuration and effective levels
  input  wire sarl_pkg::sarl_cfg_s           cfg,
  input  wire sarl_pkg::sarl_wide_t          eff_lo,
  input  wire sarl_pkg::sarl_wide_t          eff_hi,
  // Alarm state
  output logic                               qual,
  output logic                               active
);

  sarl_pkg::sarl_chan_s s, n;
  sarl_pkg::sarl_wide_t v, db, hi_lim, lo_lim;
  logic                 hit_hi, hit_lo;
  logic [15:0]          dly;

  // ===================================================================
  // Comparison and delays
  always_comb begin
    n = s;
    v  = sarl_pkg::sarl_ext(value);
    db = sarl_pkg::sarl_wide_t'({2'h0, cfg.dband});
    // Deadband widens the hold region only once the alarm is set
    hi_lim = s.qual ? sarl_pkg::sarl_wide_t'(eff_hi - db) : eff_hi;
    lo_lim = s.qual ? sarl_pkg::sarl_wide_t'(eff_lo + db) : eff_lo;
    hit_hi = cfg.hi_en && (v >= hi_lim);
    hit_lo = cfg.lo_en && (v <= lo_lim);
    if (cfg.hi_en && cfg.lo_en && (eff_hi < eff_lo)) begin
      n.qual = hit_hi && hit_lo;
    end else begin
      n.qual = hit_hi || hit_lo;
    end
    dly = s.qual ? cfg.act : cfg.rel;
    if (s.qual == s.active) begin
      n.cnt = '0;
    end else if (dly == 16'h0) begin
      n.active = s.qual;
      n.cnt    = '0;
    end else if (tick) begin
      if (16'(s.cnt + 16'h1) >= dly) begin
        n.active = s.qual;
        n.cnt    = '0;
      end else begin
        n.cnt = 16'(s.cnt + 16'h1);
      end
    end
    if (!aresetn) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s <= n;
  end

  assign qual   = s.qual;
  assign active = s.active;

  // ===================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_low_flag: assert property (
    (cfg.lo_en && !cfg.hi_en && !s.qual && v <= eff_lo) |=> s.qual)
    else $error("low level reached but alarm not flagged");
  chk_high_flag: assert property (
    (cfg.hi_en && !cfg.lo_en && !s.qual && v >= eff_hi) |=> s.qual)
    else $error("high level reached but alarm not flagged");
  chk_disabled_quiet: assert property (
    (!cfg.lo_en && !cfg.hi_en) |=> !s.qual)
    else $error("disabled levels flagged an alarm");
  chk_zero_trip: assert property (
    (s.qual && !s.active && cfg.act == 16'h0) |=> s.active)
    else $error("zero trip delay did not pass the alarm through");
  chk_lapse_clear: assert property (
    (s.qual == s.active) |=> (s.cnt == 16'h0))
    else $error("delay count kept after the condition lapsed");
  chk_trip_on_tick: assert property (
    ($rose(s.active) && $past(cfg.act) != 16'h0) |-> $past(tick))
    else $error("delayed trip without a timing tick");

  cov_trip: cover property ($rose(s.active));
  cov_delayed_reset: cover property ($fell(s.active) && cfg.rel != 16'h0);

endmodule : sarl_chan
`default_nettype wire

// file: rtl/sarl_top.sv
// Setpoint alarm comparators, relay routing and annunciators
//
// Summary of operation
// - An enabled low level flags the alarm when value is at or below it.
// - Low level can be disabled, the default; disabled never activates the alarm.
// - Low and high both enabled: alarm when value lies outside their band.
// - Annunciator flashes in alarm, steady after acknowledge, off when alarm ends.
// - One deadband per alarm, 0 to 65535, default 10, shared by both levels.
// - Active high alarm clears only below level minus deadband.
// - Active low alarm clears only above level plus deadband.
// - Deadband is in display units, the same as the measured value.
// - One trip delay per alarm, 0 to 6553.5 s, default zero, shared.
// - Relay trips only after an unbroken trip delay; a lapse restarts it.
// - One reset delay per alarm, 0 to 6553.5 s, default zero, shared.
// - Relay holds for reset delay after clearing; re-entry restarts that delay.
// - Per-alarm relay allocation bits, default off, choose which relays it drives.
// - In PI mode alarm 1 drives relay 1, alarm 2 relay 2 only.
// - Alarms 2 to 8 use own level, the default, or trail alarms 1-7.
// - Trailing level is trailed alarm's level plus own signed value.
// - High trails the high level, low trails the low; both may trail.
// - An enabled high level flags the alarm when value is at or above it.
// - High below low: alarm while value is inside the band between them.
// - Alarms sharing a relay combine by OR, or AND when selected per relay.
`timescale 1ns/100ps
`default_nettype none
`include "sarl_params.svh"

module sarl_top #(
  parameter int unsigned TICK_CYCLES = `SARL_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [`SARL_ADDR_W-1:0]       awaddr,
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic [1:0]                         bresp,
  // AXI4-Lite read
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [`SARL_ADDR_W-1:0]       araddr,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  // Measured value and acknowledge button
  input  wire logic signed [`SARL_VAL_W-1:0] display_value,
  input  wire logic                          ack_pin,
  // Relay drives and annunciators
  output logic [`SARL_NRLY-1:0]              relay_drive,
  output logic [`SARL_NRLY-1:0]              annunciator
);

  sarl_pkg::sarl_top_s  s, n;
  sarl_pkg::sarl_wide_t eff_lo [`SARL_NCH];
  sarl_pkg::sarl_wide_t eff_hi [`SARL_NCH];
  logic [`SARL_NCH-1:0] qual_v;
  logic [`SARL_NCH-1:0] act_v;
  logic                 tick;
  logic [2:0]           wch;
  logic [31:0]          wr;
  logic                 ack;
  logic                 any;
  logic                 all;
  logic                 has;
  logic                 al;

  // ===================================================================
  // Register access helpers
  function automatic logic addr_ok(input logic [`SARL_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) &&
           (!a[7] || a == `SARL_OFS_CTRL || a == `SARL_OFS_STATUS);
  endfunction : addr_ok

  function automatic logic [31:0] rd_word(input sarl_pkg::sarl_top_s st,
                                          input logic [`SARL_ADDR_W-1:0] a,
                                          input logic [`SARL_NCH-1:0] q,
                                          input logic [`SARL_NCH-1:0] ac);
    sarl_pkg::sarl_cfg_s c;
    logic [31:0]         w;
    c = st.cfg[a[6:4]];
    w = 32'h0;
    if (!a[7]) begin
      case (a[3:2])
        `SARL_OFS_LOW: begin
          w[`SARL_EN_BIT] = c.lo_en;
          w[15:0] = c.lo;
        end
        `SARL_OFS_HIGH: begin
          w[`SARL_EN_BIT] = c.hi_en;
          w[15:0] = c.hi;
        end
        `SARL_OFS_DLY: begin
          w = {c.rel, c.act};
        end
        default: begin
          w[15:0] = c.dband;
          w[`SARL_TRAIL_LSB +: 3] = c.trail;
          w[`SARL_ALLOC_LSB +: `SARL_NRLY] = c.alloc;
        end
      endcase
    end else if (a == `SARL_OFS_CTRL) begin
      w[`SARL_NRLY-1:0] = st.and_mode;
      w[`SARL_PI_BIT] = st.pi_mode;
    end else if (a == `SARL_OFS_STATUS) begin
      w[`SARL_NCH-1:0] = q;
      w[`SARL_ST_ACT_LSB +: `SARL_NCH] = ac;
      w[`SARL_ST_RLY_LSB +: `SARL_NRLY] = st.relay;
    end
    return w;
  endfunction : rd_word

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        o[8*b +: 8] = d[8*b +: 8];
      end
    end
    return o;
  endfunction : merge

  // Own level, or trailed level plus own signed offset
  function automatic sarl_pkg::sarl_wide_t eff_lvl(input logic [15:0] own,
                                                   input logic [15:0] base,
                                                   input logic [2:0]  sel);
    if (sel == 3'h0) begin
      return sarl_pkg::sarl_ext(own);
    end
    return sarl_pkg::sarl_wide_t'(sarl_pkg::sarl_ext(base) + sarl_pkg::sarl_ext(own));
  endfunction : eff_lvl

  // ===================================================================
  // Effective levels, trailing resolved
  always_comb begin
    for (int i = 0; i < `SARL_NCH; i++) begin
      // High follows the trailed high, low the trailed low
      eff_hi[i] = eff_lvl(s.cfg[i].hi, s.cfg[3'(s.cfg[i].trail - 3'h1)].hi,
                          s.cfg[i].trail);
      eff_lo[i] = eff_lvl(s.cfg[i].lo, s.cfg[3'(s.cfg[i].trail - 3'h1)].lo,
                          s.cfg[i].trail);
    end
  end

  // ===================================================================
  // Timing tick and channels
  sarl_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  for (genvar g = 0; g < `SARL_NCH; g++) begin : g_ch
    sarl_chan u_chan (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick),
      .value   (display_value),
      .cfg     (s.cfg[g]),
      .eff_lo  (eff_lo[g]),
      .eff_hi  (eff_hi[g]),
      .qual    (qual_v[g]),
      .active  (act_v[g])
    );
  end

  // ===================================================================
  // Next state
  always_comb begin
    n   = s;
    wch = s.awaddr[6:4];
    wr  = 32'h0;
    // Button passes three flops; a change counts once stages two and three agree
    n.ack_sync = {s.ack_sync[1:0], ack_pin};
    ack = 1'b0;
    if (s.ack_sync[2] == s.ack_sync[1]) begin
      n.ack_lvl = s.ack_sync[1];
      ack = s.ack_sync[1] && !s.ack_lvl;
    end

    // Write address and data may arrive in either order
    if (s.awready && awvalid) begin
      n.aw_have = 1'b1;
      n.awaddr  = awaddr;
    end
    if (s.wready && wvalid) begin
      n.w_have = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_have && n.w_have && !n.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = addr_ok(n.awaddr) ? `SARL_RESP_OKAY : `SARL_RESP_SLVERR;
      wch = n.awaddr[6:4];
      wr  = merge(rd_word(s, n.awaddr, qual_v, act_v), n.wdata, n.wstrb);
      if (n.awaddr[1:0] != 2'h0) begin
        wr = 32'h0;
      end else if (!n.awaddr[7]) begin
        case (n.awaddr[3:2])
          `SARL_OFS_LOW: begin
            n.cfg[wch].lo_en = wr[`SARL_EN_BIT];
            n.cfg[wch].lo    = wr[15:0];
          end
          `SARL_OFS_HIGH: begin
            n.cfg[wch].hi_en = wr[`SARL_EN_BIT];
            n.cfg[wch].hi    = wr[15:0];
          end
          `SARL_OFS_DLY: begin
            n.cfg[wch].act = wr[15:0];
            n.cfg[wch].rel = wr[`SARL_REL_LSB +: 16];
          end
          default: begin
            n.cfg[wch].dband = wr[15:0];
            n.cfg[wch].alloc = wr[`SARL_ALLOC_LSB +: `SARL_NRLY];
            // The first alarm has nothing ahead of it to trail
            n.cfg[wch].trail = (wch == 3'h0) ? 3'h0 : wr[`SARL_TRAIL_LSB +: 3];
          end
        endcase
      end else if (n.awaddr == `SARL_OFS_CTRL) begin
        n.and_mode = wr[`SARL_NRLY-1:0];
        n.pi_mode  = wr[`SARL_PI_BIT];
        ack        = ack || wr[`SARL_ACK_BIT];
      end
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;

    // Read answers one cycle after the address is taken
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && arvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = addr_ok(araddr) ? rd_word(s, araddr, qual_v, act_v) : 32'h0;
      n.rresp  = addr_ok(araddr) ? `SARL_RESP_OKAY : `SARL_RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Relay combining
    any = 1'b0;
    all = 1'b1;
    has = 1'b0;
    al  = 1'b0;
    for (int r = 0; r < `SARL_NRLY; r++) begin
      any = 1'b0;
      all = 1'b1;
      has = 1'b0;
      for (int c = 0; c < `SARL_NCH; c++) begin
        al = s.cfg[c].alloc[r];
        if (s.pi_mode && c < 2) begin
          al = (c == r);
        end
        has = has || al;
        any = any || (al && act_v[c]);
        all = all && (!al || act_v[c]);
      end
      n.relay[r] = s.and_mode[r] ? (has && all) : any;
    end

    // Annunciators: flash until acknowledged, then steady
    if (tick) begin
      n.blink = !s.blink;
    end
    for (int r = 0; r < `SARL_NRLY; r++) begin
      case (s.ann[r])
        sarl_pkg::SARL_ANN_OFF: begin
          if (n.relay[r]) n.ann[r] = sarl_pkg::SARL_ANN_FLASH;
        end
        sarl_pkg::SARL_ANN_FLASH: begin
          if (!n.relay[r]) n.ann[r] = sarl_pkg::SARL_ANN_OFF;
          else if (ack) n.ann[r] = sarl_pkg::SARL_ANN_STEADY;
        end
        sarl_pkg::SARL_ANN_STEADY: begin
          if (!n.relay[r]) n.ann[r] = sarl_pkg::SARL_ANN_OFF;
        end
        default: begin
          n.ann[r] = sarl_pkg::SARL_ANN_OFF;
        end
      endcase
      n.ann_out[r] = (n.ann[r] == sarl_pkg::SARL_ANN_STEADY) ||
                     ((n.ann[r] == sarl_pkg::SARL_ANN_FLASH) && n.blink);
    end

    if (!aresetn) begin
      n = '0;
      for (int i = 0; i < `SARL_NCH; i++) begin
        n.cfg[i].dband = `SARL_DBAND_RST;
      end
      for (int r = 0; r < `SARL_NRLY; r++) begin
        n.ann[r] = sarl_pkg::SARL_ANN_OFF;
      end
    end
  end

  always_ff @(posedge aclk) begin
    s <= n;
  end

  // ===================================================================
  // Outputs
  assign awready     = s.awready;
  assign wready      = s.wready;
  assign bvalid      = s.bvalid;
  assign bresp       = s.bresp;
  assign arready     = s.arready;
  assign rvalid      = s.rvalid;
  assign rdata       = s.rdata;
  assign rresp       = s.rresp;
  assign relay_drive = s.relay;
  assign annunciator = s.ann_out;

  // ===================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_first_own: assert property (
    eff_hi[0] == sarl_pkg::sarl_ext(s.cfg[0].hi))
    else $error("first alarm trails another alarm");
  chk_trail_sum: assert property (
    (s.cfg[1].trail == 3'h1) |->
      eff_lo[1] == sarl_pkg::sarl_ext(s.cfg[0].lo) + sarl_pkg::sarl_ext(s.cfg[1].lo))
    else $error("trailing low level is not base plus offset");
  chk_pi_route: assert property (
    (s.pi_mode && !s.and_mode[1] && act_v[1]) |=> s.relay[1])
    else $error("second alarm did not drive its own relay in PI mode");
  chk_flash_first: assert property (
    $rose(s.relay[0]) |-> s.ann[0] == sarl_pkg::SARL_ANN_FLASH)
    else $error("annunciator did not start flashing");
  chk_ann_clear: assert property (
    !s.relay[0] |-> !s.ann_out[0] && s.ann[0] == sarl_pkg::SARL_ANN_OFF)
    else $error("annunciator lit without relay");
  chk_bvalid_hold: assert property (
    (s.bvalid && !bready) |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped before taken");

  cov_steady: cover property (s.ann[0] == sarl_pkg::SARL_ANN_STEADY);
  cov_and_relay: cover property (s.and_mode[0] && s.relay[0]);
  cov_write: cover property (s.bvalid && bready);

endmodule : sarl_top
`default_nettype wire

// file: testbench/sarl_relay_model.sv
// Relay contacts and indicator lamps driven by the alarm block
`timescale 1ns/100ps
`default_nettype none

module sarl_relay_model (
  // Clock
  input  wire logic       aclk,
  // Coil and lamp drives
  input  wire logic [3:0] relay_drive,
  input  wire logic [3:0] annunciator,
  // Contact state and lamp changes seen
  output logic      [3:0] contact,
  output logic      [7:0] lamp_edges
);
  logic [3:0] lamp_q;

  initial begin
    contact    = 4'h0;
    lamp_edges = 8'h00;
    lamp_q     = 4'h0;
  end

  // Contacts follow the coil one cycle late, as a real relay lags its drive
  always @(posedge aclk) begin
    contact <= relay_drive;
    lamp_q  <= annunciator;
    if (lamp_q != annunciator) begin
      lamp_edges <= lamp_edges + 8'h01;
    end
  end
endmodule : sarl_relay_model
`default_nettype wire

// file: testbench/sarl_top_tb.sv
// Self-checking bench for the setpoint alarm and relay block
`timescale 1ns/100ps
`default_nettype none

module sarl_top_tb;
  localparam int TK = 10;
  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack_pin;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata;
  logic [3:0]         wstrb;
  logic signed [15:0] display_value, v;
  wire logic          awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]    bresp, rresp;
  wire logic [31:0]   rdata;
  wire logic [3:0]    relay_drive, annunciator, contact;
  wire logic [7:0]    lamp_edges;
  int                 n_errors, compares, cyc, seed;
  logic [65:0]        expq[$];
  logic [1:0]         bq[$];

  sarl_top #(.TICK_CYCLES(TK)) sarl_top_i (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .display_value(display_value), .ack_pin(ack_pin), .relay_drive(relay_drive),
    .annunciator(annunciator));
  sarl_relay_model sarl_relay_model_i (.aclk(aclk), .relay_drive(relay_drive),
    .annunciator(annunciator), .contact(contact), .lamp_edges(lamp_edges));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic fail(input string s);
    n_errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask : fail

  // Expected entry: mask, response, data
  task automatic cmp_read(input logic [65:0] e, input logic [1:0] r, input logic [31:0] d);
    compares++;
    if (r !== e[33:32] || (d & e[65:34]) !== (e[31:0] & e[65:34])) fail("read");
  endtask : cmp_read

  task automatic cmp_contact(input logic [3:0] e);
    compares++;
    if (contact !== e) fail("contact");
  endtask : cmp_contact

  // Lamp level now, and at least n lamp changes seen so far
  task automatic cmp_lamp(input logic [3:0] e, input logic [7:0] n);
    compares++;
    if (annunciator !== e || (lamp_edges >= n) !== 1'b1) fail("lamp");
  endtask : cmp_lamp

  task automatic cmp_write(input logic [1:0] e, input logic [1:0] r);
    compares++;
    if (r !== e) fail("write response");
  endtask : cmp_write

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bq.push_back(((a[7] && a != 8'h80 && a != 8'h84) || a[1:0] != 2'h0) ? 2'h2 : 2'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // The requests only show after this time step, so wait an edge first
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] r,
                    input logic [31:0] d);
    expq.push_back({m, r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (arvalid || rready);
  endtask : rd

  // Compare process: oldest note against each read answer
  always @(posedge aclk) begin
    cyc++;
    if (rvalid && rready) begin
      if (expq.size() == 0) fail("unexpected read");
      else cmp_read(expq.pop_front(), rresp, rdata);
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) fail("unexpected write answer");
      else cmp_write(bq.pop_front(), bresp);
    end
    if (cyc == 20000) begin
      fail("timeout");
      end_of_test();
    end
  end

  // Three cycles from value to relay, one spare
  task automatic dv(input logic signed [15:0] x);
    display_value <= x;
    repeat (4) @(posedge aclk);
  endtask : dv

  initial begin
    seed = 32'h8b78;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ack_pin} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    display_value = 16'sh0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(8'h00, '1, 2'h0, 32'h0);
    rd(8'h0c, '1, 2'h0, 32'h0000000a);
    rd(8'h90, '1, 2'h2, 32'h0);
    // Low level 100 on alarm 0 routed to relay 0
    wr(8'h0c, 32'h0010000a);
    wr(8'h00, 32'h80000064);
    dv(16'sd100);
    rd(8'h84, 32'h00010101, 2'h0, 32'h00010101);
    cmp_contact(4'h1);
    // Let the lamp flash a few ticks, then acknowledge from the button
    repeat (3 * TK) @(posedge aclk);
    ack_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    ack_pin <= 1'b0;
    cmp_lamp(4'h1, 8'h02);
    dv(16'sd110);
    rd(8'h84, 32'h1, 2'h0, 32'h1);
    dv(16'sd111);
    rd(8'h84, 32'h1, 2'h0, 32'h0);
    cmp_lamp(4'h0, 8'h02);
    // High level 50 on alarm 1, deadband 3
    dv(16'sd0);
    wr(8'h1c, 32'h00000003);
    wr(8'h14, 32'h80000032);
    dv(16'sd50);
    rd(8'h84, 32'h2, 2'h0, 32'h2);
    dv(16'sd47);
    rd(8'h84, 32'h2, 2'h0, 32'h2);
    dv(16'sd46);
    rd(8'h84, 32'h2, 2'h0, 32'h0);
    // Alarm 2: trip delay of two ticks, reset delay of three
    wr(8'h2c, 32'h0);
    wr(8'h28, 32'h00030002);
    wr(8'h24, 32'h800003e8);
    dv(16'sd1000);
    rd(8'h84, 32'h404, 2'h0, 32'h004);
    repeat (3 * TK) @(posedge aclk);
    rd(8'h84, 32'h404, 2'h0, 32'h404);
    dv(16'sd0);
    rd(8'h84, 32'h404, 2'h0, 32'h400);
    repeat (4 * TK) @(posedge aclk);
    rd(8'h84, 32'h404, 2'h0, 32'h0);
    // Alarm 3 outside -100..100, alarm 4 inside it, both on relay 2
    wr(8'h3c, 32'h00400000);
    wr(8'h30, 32'h8000ff9c);
    wr(8'h34, 32'h80000064);
    wr(8'h4c, 32'h00400000);
    wr(8'h40, 32'h80000064);
    wr(8'h44, 32'h8000ff9c);
    // Alarm 5 trails the high level of alarm 1 by 20, so trips at 70
    wr(8'h5c, 32'h00020000);
    wr(8'h54, 32'h80000014);
    repeat (8) begin
      v = 16'($random(seed) % 160);
      dv(v);
      rd(8'h84, 32'h38, 2'h0, {26'h0, v >= 70, v >= -100 && v <= 100,
         v <= -100 || v >= 100, 3'h0});
    end
    // PI mode pins alarms 0 and 1 to relays 0 and 1; relay 2 in AND mode
    wr(8'h80, 32'h00000104);
    wr(8'h88, 32'h0);
    dv(16'sd60);
    rd(8'h84, 32'h000f0000, 2'h0, 32'h00030000);
    dv(16'sd100);
    rd(8'h84, 32'h000f0000, 2'h0, 32'h00070000);
    repeat (4) @(posedge aclk);
    end_of_test();
  end
endmodule : sarl_top_tb
`default_nettype wire
